// ==== shared/clas_regs.vh ====
`ifndef CLAS_REGS_VH
`define CLAS_REGS_VH
// Register byte offsets on the AXI4-Lite slave.
`define CLAS_OFF_ACCESS 8'h00
`define CLAS_OFF_TAG 8'h04
`define CLAS_OFF_TAG_CLR 8'h08
`define CLAS_OFF_TAG_SET 8'h0C
`define CLAS_OFF_TAG_INV 8'h10
`define CLAS_OFF_MASK 8'h14
`define CLAS_OFF_MASK_CLR 8'h18
`define CLAS_OFF_MASK_SET 8'h1C
`define CLAS_OFF_MASK_INV 8'h20
`define CLAS_OFF_WORD0 8'h24
`define CLAS_OFF_WORD1 8'h28
`define CLAS_OFF_WORD2 8'h2C
`define CLAS_OFF_WORD3 8'h30
`define CLAS_OFF_LRU 8'h34
`define CLAS_OFF_HIT 8'h38
`define CLAS_OFF_MISS 8'h3C
// Field positions and implemented-bit masks.
`define CLAS_ACC_IDX_MSB 3
`define CLAS_ACC_WEN_BIT 31
`define CLAS_TAG_IMPL 32'h80FF_FFFE
`define CLAS_MASK_IMPL 32'h0000_FFE0
`define CLAS_MASK_LINE_A 4'hA
`define CLAS_MASK_LINE_B 4'hB
// Reset values.
`define CLAS_ACC_RESET 32'h0000_0000
`define CLAS_TAG_RESET 32'h0000_0002
`define CLAS_MASK_RESET 32'h0000_0000
`define CLAS_LRU_RESET 25'h000_0000
// Bus answer codes.
`define CLAS_RESP_OKAY 2'b00
`define CLAS_RESP_SLVERR 2'b10
`define CLAS_UNDEF_READ 32'h0000_0000
`endif

// ==== hw/clas_line_store.v ====
`timescale 1ns/100ps
`include "clas_regs.vh"
// Per-line tag, mask and 128-bit data storage, one port addressed by line index.
module clas_line_store (
  aclk,
  aresetn,
  line_index,
  tag_we,
  tag_wdata,
  mask_we,
  mask_wdata,
  word_we,
  word_sel,
  word_wdata,
  tag_rdata,
  mask_rdata,
  word_rdata
);
  input wire aclk;
  input wire aresetn;
  input wire [3:0] line_index;
  input wire tag_we;
  input wire [31:0] tag_wdata;
  input wire mask_we;
  input wire [31:0] mask_wdata;
  input wire word_we;
  input wire [1:0] word_sel;
  input wire [31:0] word_wdata;
  output wire [31:0] tag_rdata;
  output wire [31:0] mask_rdata;
  output wire [31:0] word_rdata;

  reg [31:0] tag_mem [0:15];
  reg [31:0] mask_mem [0:15];
  reg [31:0] data_mem [0:63];
  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // Tag and mask arrays reset so every line starts invalid and unmasked.
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_line
      always @(posedge aclk) begin
        if (!aresetn) begin
          tag_mem[g] <= `CLAS_TAG_RESET;
          mask_mem[g] <= `CLAS_MASK_RESET;
        end else begin
          if (tag_we && line_index == g) begin
            tag_mem[g] <= tag_wdata & `CLAS_TAG_IMPL;
          end
          if (mask_we && line_index == g) begin
            mask_mem[g] <= mask_wdata & `CLAS_MASK_IMPL;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data array has no reset; its content after power-on is unknown.
  always @(posedge aclk) begin
    if (word_we) begin
      data_mem[{line_index, word_sel}] <= word_wdata;
    end
  end

  assign tag_rdata = tag_mem[line_index];
  assign mask_rdata = mask_mem[line_index];
  assign word_rdata = data_mem[{line_index, word_sel}];
endmodule // clas_line_store

// ==== hw/clas_top.v ====
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "clas_regs.vh"
module clas_top (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awprot,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arprot,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  code_protect,
  replacement_state,
  access_valid,
  access_cacheable,
  access_is_fetch,
  access_hit,
  lookup_addr,
  line_address_mask
);
  input wire aclk;
  input wire aresetn;
  input wire [7:0] s_axi_awaddr;
  input wire [2:0] s_axi_awprot;
  input wire s_axi_awvalid;
  output wire s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output wire s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr;
  input wire [2:0] s_axi_arprot;
  input wire s_axi_arvalid;
  output wire s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire code_protect;
  input wire [24:0] replacement_state;
  input wire access_valid;
  input wire access_cacheable;
  input wire access_is_fetch;
  input wire access_hit;
  input wire [3:0] lookup_addr;
  output reg [10:0] line_address_mask;

  reg [7:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;
  reg [31:0] access_reg;
  reg [31:0] hit_count_reg;
  reg [31:0] miss_count_reg;
  reg [24:0] lru_reg;
  reg prot_meta_reg;
  reg prot_reg;
  wire [3:0] line_index;
  wire tag_write_enable;
  wire wr_fire;
  wire [31:0] tag_rdata;
  wire [31:0] mask_rdata;
  wire [31:0] word_rdata;
  reg tag_we;
  reg [31:0] tag_wdata;
  reg mask_we;
  reg [31:0] mask_wdata;
  reg word_we;
  reg wr_ok;
  reg [31:0] wr_merged;
  reg [31:0] rd_data;
  reg rd_ok;
  reg [10:0] mask_a_reg, mask_b_reg;

  // Byte-lane merge: a lane left unstrobed keeps the old byte.
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
      end
    end
  endfunction

  // Strobed alias write data: unstrobed lanes act as zeros, leaving bits alone.
  function [31:0] lane_bits;
    input [31:0] val;
    input [3:0] strb;
    begin
      lane_bits = lane_merge(32'h0000_0000, val, strb);
    end
  endfunction

  // Only lines 10 and 11 carry an address mask.
  function mask_line;
    input [3:0] idx;
    begin
      mask_line = (idx == `CLAS_MASK_LINE_A) || (idx == `CLAS_MASK_LINE_B);
    end
  endfunction

  assign line_index = access_reg[`CLAS_ACC_IDX_MSB:0];
  assign tag_write_enable = access_reg[`CLAS_ACC_WEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data captured independently in either order.
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CLAS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CLAS_RESP_OKAY : `CLAS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode into the line store; alias operations act on the read port.
  always @* begin
    tag_we = 1'b0;
    mask_we = 1'b0;
    word_we = 1'b0;
    wr_ok = 1'b1;
    tag_wdata = tag_rdata;
    mask_wdata = mask_rdata;
    wr_merged = lane_merge(word_rdata, w_data_reg, w_strb_reg);
    case (aw_addr_reg & 8'hFC)
      `CLAS_OFF_TAG: begin
        tag_we = wr_fire && tag_write_enable;
        tag_wdata = lane_merge(tag_rdata, w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_TAG_CLR: begin
        tag_we = wr_fire && tag_write_enable;
        tag_wdata = tag_rdata & ~lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_TAG_SET: begin
        tag_we = wr_fire && tag_write_enable;
        tag_wdata = tag_rdata | lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_TAG_INV: begin
        tag_we = wr_fire && tag_write_enable;
        tag_wdata = tag_rdata ^ lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_MASK: begin
        mask_we = wr_fire && mask_line(line_index);
        mask_wdata = lane_merge(mask_rdata, w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_MASK_CLR: begin
        mask_we = wr_fire && mask_line(line_index);
        mask_wdata = mask_rdata & ~lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_MASK_SET: begin
        mask_we = wr_fire && mask_line(line_index);
        mask_wdata = mask_rdata | lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_MASK_INV: begin
        mask_we = wr_fire && mask_line(line_index);
        mask_wdata = mask_rdata ^ lane_bits(w_data_reg, w_strb_reg);
      end
      `CLAS_OFF_WORD0, `CLAS_OFF_WORD1, `CLAS_OFF_WORD2, `CLAS_OFF_WORD3: begin
        word_we = wr_fire;
      end
      `CLAS_OFF_ACCESS, `CLAS_OFF_HIT, `CLAS_OFF_MISS, `CLAS_OFF_LRU: wr_ok = 1'b1;
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line storage; word select comes from whichever channel is active.
  clas_line_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_index(line_index),
    .tag_we(tag_we),
    .tag_wdata(tag_wdata),
    .mask_we(mask_we),
    .mask_wdata(mask_wdata),
    .word_we(word_we),
    .word_sel(wr_fire ? aw_addr_reg[3:2] - 2'd1 : s_axi_araddr[3:2] - 2'd1),
    .word_wdata(wr_merged),
    .tag_rdata(tag_rdata),
    .mask_rdata(mask_rdata),
    .word_rdata(word_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access control, mask shadows and the registered replacement-state view.
  // A software write to a counter wins over a same-cycle count event.
  always @(posedge aclk) begin
    if (!aresetn) begin
      access_reg <= `CLAS_ACC_RESET;
      lru_reg <= `CLAS_LRU_RESET;
      prot_meta_reg <= 1'b1;
      prot_reg <= 1'b1;
      mask_a_reg <= 11'h000;
      mask_b_reg <= 11'h000;
    end else begin
      lru_reg <= replacement_state;
      if (mask_we) begin
        mask_a_reg <= line_index[0] ? mask_a_reg : mask_wdata[15:5];
        mask_b_reg <= line_index[0] ? mask_wdata[15:5] : mask_b_reg;
      end
      prot_meta_reg <= code_protect;
      prot_reg <= prot_meta_reg;
      if (wr_fire && (aw_addr_reg & 8'hFC) == `CLAS_OFF_ACCESS) begin
        access_reg <= lane_merge(access_reg, w_data_reg, w_strb_reg) & 32'h8000_000F;
      end
    end
  end

  // Counters have no reset: their content after power-on is unspecified.
  always @(posedge aclk) begin
    if (wr_fire && (aw_addr_reg & 8'hFC) == `CLAS_OFF_HIT) begin
      hit_count_reg <= lane_merge(hit_count_reg, w_data_reg, w_strb_reg);
    end else if (access_valid && access_cacheable && access_hit) begin
      hit_count_reg <= hit_count_reg + 32'h0000_0001;
    end
    if (wr_fire && (aw_addr_reg & 8'hFC) == `CLAS_OFF_MISS) begin
      miss_count_reg <= lane_merge(miss_count_reg, w_data_reg, w_strb_reg);
    end else if (access_valid && access_cacheable && access_is_fetch && !access_hit) begin
      miss_count_reg <= miss_count_reg + 32'h0000_0001;
    end
  end

  // Shadows feed the compare, since the store's read port follows the software index.
  always @* begin
    line_address_mask = 11'h000;
    if (mask_line(lookup_addr)) begin
      line_address_mask = lookup_addr[0] ? mask_b_reg : mask_a_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, data one cycle after address taken.
  assign s_axi_arready = !s_axi_rvalid && !wr_fire;

  always @* begin
    rd_ok = 1'b1;
    rd_data = `CLAS_UNDEF_READ;
    case (s_axi_araddr & 8'hFC)
      `CLAS_OFF_ACCESS: rd_data = access_reg;
      `CLAS_OFF_TAG: rd_data = tag_rdata;
      `CLAS_OFF_MASK: rd_data = mask_rdata & `CLAS_MASK_IMPL;
      `CLAS_OFF_TAG_CLR, `CLAS_OFF_TAG_SET, `CLAS_OFF_TAG_INV,
      `CLAS_OFF_MASK_CLR, `CLAS_OFF_MASK_SET, `CLAS_OFF_MASK_INV: rd_data = `CLAS_UNDEF_READ;
      `CLAS_OFF_WORD0, `CLAS_OFF_WORD1, `CLAS_OFF_WORD2, `CLAS_OFF_WORD3: begin
        rd_data = prot_reg ? 32'h0000_0000 : word_rdata;
      end
      `CLAS_OFF_LRU: rd_data = {7'h00, lru_reg};
      `CLAS_OFF_HIT: rd_data = hit_count_reg;
      `CLAS_OFF_MISS: rd_data = miss_count_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CLAS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready && !wr_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? `CLAS_RESP_OKAY : `CLAS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // clas_top

// ==== bench/clas_top_asserts.sv ====
`timescale 1ns/100ps
`include "clas_regs.vh"
// Port-level checks on the register bus handshakes and the mask output.
module clas_top_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] lookup_addr,
  input wire [10:0] line_address_mask
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Nothing held and nothing offered, so no write can land at the next edge.
  sequence s_wr_idle;
    s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  // Address and data accepted together.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Answers stand until taken.
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped or changed");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped or changed");
  AST_RD_ONE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  AST_WR_RESP: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_wr_idle ##0 (s_axi_arvalid && s_axi_arready) |=>
    s_axi_rvalid) else $error("read answer late");
  AST_RD_UNMAPPED: assert property (s_wr_idle ##0 (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h3C) |=> s_axi_rresp == `CLAS_RESP_SLVERR)
    else $error("unmapped read not refused");
  // Only lines ten and eleven may ever present a mask.
  AST_MASK_OFF: assert property (lookup_addr != `CLAS_MASK_LINE_A &&
    lookup_addr != `CLAS_MASK_LINE_B |-> line_address_mask == 11'h000)
    else $error("mask shown on unmasked line");
  AST_MASK_STABLE: assert property (s_wr_idle |=>
    ($stable(lookup_addr) -> $stable(line_address_mask)))
    else $error("mask changed without a write");
endmodule // clas_top_chk

bind clas_top clas_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .lookup_addr, .line_address_mask);

// ==== bench/clas_core_model.sv ====
`timescale 1ns/100ps
// Core side of the cache: at most one fetch or load per cycle while run is high.
module clas_core_model (
  input wire aclk,
  input wire run,
  output logic access_valid,
  output logic access_cacheable,
  output logic access_is_fetch,
  output logic access_hit
);
  integer seed = 32'h37be;
  logic [31:0] r = 32'h0000_0000;
  initial {access_valid, access_cacheable, access_is_fetch, access_hit} = 4'h0;
  // Qualifiers change every cycle, valid or not, so nothing may lean on stale values.
  always @(posedge aclk) begin
    r <= $random(seed);
    access_valid <= run & r[0];
    access_cacheable <= r[1] | r[2];
    access_is_fetch <= r[3];
    access_hit <= r[4];
  end
endmodule // clas_core_model

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`include "clas_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, code_protect = 1'b1, run = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, lookup_addr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [24:0] replacement_state = 25'h000_0000;
  logic access_valid, access_cacheable, access_is_fetch, access_hit;
  logic [10:0] line_address_mask;
  integer seed = 32'h37be, failures = 0, tests_run = 0, exp_hit = 0, exp_miss = 0, i, k;
  logic [31:0] acc_m, d, tag_m[16], msk_m[16], wd_m[16][4];
  clas_top u_dut (.*);
  clas_core_model u_core (.*);
  initial forever #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Reference counters follow the core's accesses at the same edges as the block.
  always @(posedge aclk) begin
    if (aresetn && access_valid && access_cacheable) begin
      if (access_hit) exp_hit++;
      else if (access_is_fetch) exp_miss++;
    end
  end
  // Clear, set and invert act only on implemented bits; the rest keep their value.
  function automatic logic [31:0] upd(input logic [7:0] op, input logic [31:0] o, dv, im);
    logic [31:0] n;
    case (op[3:2])
      2'h0: n = dv;
      2'h1: n = o & ~dv;
      2'h2: n = o | dv;
      default: n = o ^ dv;
    endcase
    return (n & im) | (o & ~im);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Bus write; both channels offered together, each dropped once taken.
  task bus_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
    integer n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 100) failures++;
    end
  endtask
  // Write through the bus and mirror the effect in the reference model.
  task wr(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] r;
    logic [1:0] w;
    logic [3:0] x;
    begin
      x = acc_m[3:0];
      w = a[3:2] - 2'h1;
      bus_wr(a, dv, r);
      `CHK(r, a > 8'h3C ? `CLAS_RESP_SLVERR : `CLAS_RESP_OKAY)
      if (a == `CLAS_OFF_ACCESS) acc_m = dv;
      if (a >= 8'h04 && a <= 8'h10 && acc_m[31])
        tag_m[x] = upd(a - 8'h04, tag_m[x], dv, `CLAS_TAG_IMPL);
      if (a >= 8'h14 && a <= 8'h20 && x[3:1] == 3'h5)
        msk_m[x] = upd(a - 8'h14, msk_m[x], dv, `CLAS_MASK_IMPL);
      if (a >= 8'h24 && a <= 8'h30) wd_m[x][w] = dv;
    end
  endtask
  // Bus read and comparison; an unmapped place must be refused.
  task rd(input logic [7:0] a, input logic [31:0] e);
    integer n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 100) failures++;
      `CHK(s_axi_rresp, a > 8'h3C ? `CLAS_RESP_SLVERR : `CLAS_RESP_OKAY)
      if (a < 8'h40) `CHK(s_axi_rdata, e)
    end
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well past the expected run length.
  initial begin
    #50000;
    failures++;
    stop_test;
  end
  // Main sequence.
  initial begin
    for (i = 0; i < 16; i++) begin
      tag_m[i] = `CLAS_TAG_RESET;
      msk_m[i] = `CLAS_MASK_RESET;
    end
    acc_m = `CLAS_ACC_RESET;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CLAS_OFF_TAG, `CLAS_TAG_RESET);
    rd(`CLAS_OFF_MASK, `CLAS_MASK_RESET);
    endt("reset");
    // Every tag operation, first with the write enable off, then on.
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(`CLAS_OFF_ACCESS, {i[2], 27'h000_0000, d[3:0]});
      d = $random(seed);
      if (i[1:0] == 2'h0) d = d & `CLAS_TAG_IMPL;
      wr(`CLAS_OFF_TAG + 8'(4 * i[1:0]), d);
      rd(`CLAS_OFF_TAG, tag_m[acc_m[3:0]]);
    end
    endt("tag");
    // Every mask operation on an unmasked line and on both masked lines.
    for (i = 0; i < 12; i++) begin
      k = (i < 4) ? 3 : ((i < 8) ? 10 : 11);
      wr(`CLAS_OFF_ACCESS, k);
      d = $random(seed);
      if (i % 4 == 0) d = d & `CLAS_MASK_IMPL;
      wr(`CLAS_OFF_MASK + 8'(4 * (i % 4)), d);
      rd(`CLAS_OFF_MASK, msk_m[k]);
      lookup_addr <= k[3:0];
      repeat (2) @(posedge aclk);
      `CHK(line_address_mask, msk_m[k][15:5])
    end
    // Line ten's mask must reach the compare while the index still selects line eleven.
    lookup_addr <= 4'hA;
    repeat (2) @(posedge aclk);
    `CHK(line_address_mask, msk_m[10][15:5])
    endt("mask");
    // Data window, open and then hidden by code protection.
    wr(`CLAS_OFF_ACCESS, 32'h0000_0005);
    code_protect <= 1'b0;
    for (i = 0; i < 4; i++) wr(`CLAS_OFF_WORD0 + 8'(4 * i), $random(seed));
    for (i = 0; i < 4; i++) rd(`CLAS_OFF_WORD0 + 8'(4 * i), wd_m[5][i]);
    code_protect <= 1'b1;
    repeat (4) @(posedge aclk);
    for (i = 0; i < 4; i++) rd(`CLAS_OFF_WORD0 + 8'(4 * i), `CLAS_UNDEF_READ);
    endt("words");
    // Replacement state is mirrored with the reserved top bits at zero.
    d = $random(seed);
    replacement_state <= d[24:0];
    repeat (3) @(posedge aclk);
    rd(`CLAS_OFF_LRU, {7'h00, d[24:0]});
    wr(`CLAS_OFF_LRU, 32'h01FF_FFFF);
    rd(`CLAS_OFF_LRU, {7'h00, d[24:0]});
    endt("lru");
    // Counters preset by software, then driven by random core traffic.
    d = $random(seed);
    wr(`CLAS_OFF_HIT, d);
    wr(`CLAS_OFF_MISS, ~d);
    exp_hit = d;
    exp_miss = ~d;
    run <= 1'b1;
    repeat (200) @(posedge aclk);
    run <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(`CLAS_OFF_HIT, exp_hit);
    rd(`CLAS_OFF_MISS, exp_miss);
    endt("counters");
    // Unmapped place is refused both ways.
    wr(8'h40, $random(seed));
    rd(8'h40, 32'h0000_0000);
    endt("unmapped");
    stop_test;
  end
endmodule // tb_top
